// File: acq_pkg.sv
`default_nettype none
package acq_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_OUTCODE = 8'h04;
  localparam logic [7:0] OFF_CHSEL = 8'h08;
  localparam logic [7:0] OFF_GAIN = 8'h0C;
  localparam logic [7:0] OFF_MODE = 8'h10;
  localparam logic [7:0] OFF_SWTRIG = 8'h14;
  localparam logic [7:0] OFF_FIFORST = 8'h18;
  localparam logic [7:0] OFF_PACER1 = 8'h1C;
  localparam logic [7:0] OFF_PACER2 = 8'h20;
  // mode bit positions
  localparam int MODE_PRETRIG = 0;
  localparam int MODE_EXTSRC = 1;
  localparam int MODE_PACER = 2;
  localparam int MODE_AUTOSCAN = 3;
  // status bit positions in the gain register read
  localparam int ST_EMPTY = 4;
  localparam int ST_HALF = 5;
  localparam int ST_FULL = 6;
  localparam int ST_BUSY = 7;
  // reset values and limits
  localparam logic [2:0] GAIN_X1 = 3'h0;
  localparam logic [2:0] GAIN_MAX = 3'h4;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam int CONV_CYCLES = 4;
  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_STORE} conv_state_t;
endpackage : acq_pkg
`default_nettype wire

// File: acq_control.sv
// The implementer's own choices: the APB slave port and the address map.
`default_nettype none
// What this block does
// - one 12-bit output code channel, 0 to 4095, written by host
// - sixteen input channels chosen by a 4-bit number
// - auto-scan off: convert only the last written channel
// - auto-scan on: written number is the ending channel
// - channel read: bits 0-3 programmed number, bits 4-7 zero without scan
// - auto-scan on: bits 4-7 show the sequencer's current channel
// - after reset the gain is x1, the plus/minus ten volt range
// - five gains x1 to x16 selectable
// - gain setting reads back
// - gain address read also shows fifo empty and half-full flags
// - full flag set when fifo fills, results may be lost
// - busy flag while a conversion runs and stores
// - mode register picks source, pacer on/off, auto-scan; the pretrigger bit is only stored
// - mode options are independent bits written together
// - mode setting reads back
// - each data port read returns one conversion result, zero when the fifo is empty
// - repeated data reads return results in stored order
// - software trigger write starts one conversion when idle and the external source is not selected
// - fifo reset discards all stored results
// - pacer stops when either divider is zero
module acq_control
  import acq_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter side
  input wire logic extTrigger,
  input wire logic [11:0] convData,
  output logic [11:0] outputCode,
  output logic [3:0] muxSelect,
  output logic [2:0] gainSetting,
  output logic convStart
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire rdEn = access && !pwrite;
  wire hitData = paddr == OFF_DATA;
  wire hitOut = paddr == OFF_OUTCODE;
  wire hitChan = paddr == OFF_CHSEL;
  wire hitGain = paddr == OFF_GAIN;
  wire hitMode = paddr == OFF_MODE;
  wire hitSoft = paddr == OFF_SWTRIG;
  wire hitRst = paddr == OFF_FIFORST;
  wire hitP1 = paddr == OFF_PACER1;
  wire hitP2 = paddr == OFF_PACER2;
  wire mapped = hitData | hitOut | hitChan | hitGain | hitMode | hitSoft
              | hitRst | hitP1 | hitP2;

  // ****************************************************************
  // host registers
  // ****************************************************************
  logic [11:0] outCode_q;
  logic [3:0] chanSel_q;
  logic [2:0] gain_q;
  logic [3:0] mode_q;
  logic [15:0] div1_q, div2_q;
  wire gainOk = pwdata[2:0] <= GAIN_MAX;

  // writes land on the access edge only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      outCode_q <= 12'h000;
      chanSel_q <= 4'h0;
      gain_q <= GAIN_X1;
      mode_q <= MODE_RESET;
      div1_q <= 16'h0000;
      div2_q <= 16'h0000;
    end else if (wrEn) begin
      if (hitOut) outCode_q <= pwdata[11:0];
      if (hitChan) chanSel_q <= pwdata[3:0];
      if (hitGain && gainOk) gain_q <= pwdata[2:0];
      if (hitMode) mode_q <= pwdata[3:0];
      if (hitP1) div1_q <= pwdata[15:0];
      if (hitP2) div2_q <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // trigger sources
  // ****************************************************************
  logic ext1_q, ext2_q, ext3_q;
  logic [15:0] cnt1_q, cnt2_q;
  wire autoScan = mode_q[MODE_AUTOSCAN];
  wire pacerOn = mode_q[MODE_PACER] && div1_q != 16'h0000
               && div2_q != 16'h0000;
  wire tick1 = cnt1_q == 16'h0000;
  wire pacerFire = pacerOn && tick1 && cnt2_q == 16'h0000;
  wire extFire = ext2_q && !ext3_q;
  wire softFire = wrEn && hitSoft;
  // the external source shuts out soft and pacer triggers, so one source owns the converter
  wire trigger = mode_q[MODE_EXTSRC] ? extFire : (softFire || pacerFire);

  // external trigger synchroniser; edge taken after the second stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext1_q <= 1'b0;
      ext2_q <= 1'b0;
      ext3_q <= 1'b0;
    end else begin
      ext1_q <= extTrigger;
      ext2_q <= ext1_q;
      ext3_q <= ext2_q;
    end
  end

  // two cascaded dividers; held at reload while the pacer is off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt1_q <= 16'h0000;
      cnt2_q <= 16'h0000;
    end else if (!pacerOn) begin
      cnt1_q <= div1_q - 16'h0001;
      cnt2_q <= div2_q - 16'h0001;
    end else if (tick1) begin
      cnt1_q <= div1_q - 16'h0001;
      cnt2_q <= (cnt2_q == 16'h0000) ? div2_q - 16'h0001 : cnt2_q - 16'h0001;
    end else begin
      cnt1_q <= cnt1_q - 16'h0001;
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  conv_state_t state_q;
  logic [2:0] wait_q;
  logic [3:0] scanCh_q;
  wire convDone = state_q == CONV_STORE;
  wire [3:0] convCh = autoScan ? scanCh_q : chanSel_q;
  // a trigger during a running conversion is dropped, the converter cannot queue

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= CONV_IDLE;
      wait_q <= 3'h0;
    end else begin
      unique case (state_q)
        CONV_IDLE: if (trigger) begin
          state_q <= CONV_RUN;
          wait_q <= 3'(CONV_CYCLES - 1);
        end
        CONV_RUN: if (wait_q == 3'h0) state_q <= CONV_STORE;
          else wait_q <= wait_q - 3'h1;
        CONV_STORE: state_q <= CONV_IDLE;
      endcase
    end
  end

  // scan pointer steps after each stored result, wraps past the end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) scanCh_q <= 4'h0;
    else if (!autoScan) scanCh_q <= 4'h0;
    else if (convDone) scanCh_q <= (scanCh_q >= chanSel_q) ? 4'h0 : scanCh_q + 4'h1;
  end

  // ****************************************************************
  // result fifo
  // ****************************************************************
  logic [11:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] count_q;
  logic full_q;
  logic popArm_q;
  wire popReq = rdEn && hitData;
  wire flush = wrEn && hitRst;
  // a result that meets a full fifo is lost; the full flag, cleared by the next data read, tells software
  wire push = convDone && count_q != (AW+1)'(DEPTH);
  // pop only behind a setup that saw data, so a result pushed in between is kept
  wire pop = popReq && popArm_q;
  wire [AW:0] cntNext = count_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock) begin
    if (push) mem[wp_q] <= convData;
  end

  // pointers; flush wins over any same-cycle push or pop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      count_q <= '0;
      full_q <= 1'b0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      count_q <= '0;
      full_q <= 1'b0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      count_q <= cntNext;
      if (cntNext == (AW+1)'(DEPTH)) full_q <= 1'b1;
      else if (pop && !push) full_q <= 1'b0;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [3:0] hiNib = autoScan ? scanCh_q : 4'h0;
  // status nibble: busy, full, half (from half the depth upward), empty
  wire [3:0] status = {state_q != CONV_IDLE, full_q,
                       count_q >= (AW+1)'(DEPTH / 2), count_q == '0};
  wire [31:0] rdMux =
      hitData ? {20'h00000, (count_q != '0) ? mem[rp_q] : 12'h000} :
      hitOut ? {20'h00000, outCode_q} :
      hitChan ? {24'h000000, hiNib, chanSel_q} :
      hitGain ? {24'h000000, status[3:0], 1'b0, gain_q} :
      hitMode ? {28'h0000000, mode_q} :
      hitP1 ? {16'h0000, div1_q} :
      hitP2 ? {16'h0000, div2_q} : 32'h00000000;

  // bus answer: one wait-free access phase, data registered at setup
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      popArm_q <= 1'b0;
    end else begin
      pready <= psel && !penable;
      popArm_q <= psel && !penable && !pwrite && hitData && count_q != '0;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) prdata <= rdMux;
    end
  end

  // converter outputs from flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      outputCode <= 12'h000;
      muxSelect <= 4'h0;
      gainSetting <= GAIN_X1;
      convStart <= 1'b0;
    end else begin
      outputCode <= outCode_q;
      muxSelect <= convCh;
      gainSetting <= gain_q;
      convStart <= state_q == CONV_IDLE && trigger;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // low nibble of a write, kept for the register checks
  wire [3:0] wrNib = pwdata[3:0];

  // reset and register writes
  gain_reset_a: assert property (@(posedge clock) $rose(rstn) |-> gain_q == GAIN_X1)
    else $error("gain not x1 after reset");
  gain_code_a: assert property (@(posedge clock) disable iff (!rstn) gain_q <= GAIN_MAX)
    else $error("illegal gain code stored");
  gain_keep_a: assert property (@(posedge clock) disable iff (!rstn)
      (wrEn && hitGain && !gainOk) |=> $stable(gain_q))
    else $error("unused gain code was stored");
  gain_out_a: assert property (@(posedge clock) disable iff (!rstn)
      gainSetting == $past(gain_q))
    else $error("gain output not following register");
  out_follow_a: assert property (@(posedge clock) disable iff (!rstn)
      outputCode == $past(outCode_q))
    else $error("output code not following register");
  chan_write_a: assert property (@(posedge clock) disable iff (!rstn)
      (wrEn && hitChan) |=> chanSel_q == $past(wrNib))
    else $error("channel number not stored");
  mode_write_a: assert property (@(posedge clock) disable iff (!rstn)
      (wrEn && hitMode) |=> mode_q == $past(wrNib))
    else $error("mode bits not stored together");

  // triggers and conversion timing
  soft_start_a: assert property (@(posedge clock) disable iff (!rstn)
      (softFire && !mode_q[MODE_EXTSRC] && state_q == CONV_IDLE) |=> convStart)
    else $error("soft trigger did not start");
  soft_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
      convStart |=> !convStart)
    else $error("start pulse longer than one cycle");
  ext_only_a: assert property (@(posedge clock) disable iff (!rstn)
      (mode_q[MODE_EXTSRC] && !extFire) |=> !convStart)
    else $error("start without external edge");
  busy_run_a: assert property (@(posedge clock) disable iff (!rstn)
      convStart |-> state_q == CONV_RUN)
    else $error("busy missing during conversion");
  conv_len_a: assert property (@(posedge clock) disable iff (!rstn)
      convStart |-> ##4 convDone)
    else $error("conversion did not store on time");
  pacer_stop_a: assert property (@(posedge clock) disable iff (!rstn)
      (div1_q == 16'h0000 || div2_q == 16'h0000) |-> !pacerFire)
    else $error("pacer fired with zero divider");

  // scan sequencer
  fixed_chan_a: assert property (@(posedge clock) disable iff (!rstn)
      !autoScan |=> muxSelect == $past(chanSel_q))
    else $error("fixed channel not selected");
  scan_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !autoScan |=> scanCh_q == 4'h0)
    else $error("scan pointer moved with scan off");
  scan_step_a: assert property (@(posedge clock) disable iff (!rstn)
      (autoScan && convDone && scanCh_q < chanSel_q && !(wrEn && hitMode))
      |=> scanCh_q == $past(scanCh_q) + 4'h1)
    else $error("scan did not step by one");
  scan_wrap_a: assert property (@(posedge clock) disable iff (!rstn)
      (autoScan && convDone && scanCh_q >= chanSel_q && !(wrEn && hitMode)) |=> scanCh_q == 4'h0)
    else $error("scan did not wrap");

  // result fifo
  flush_empty_a: assert property (@(posedge clock) disable iff (!rstn)
      flush |=> count_q == '0)
    else $error("fifo not empty after flush");
  full_flag_a: assert property (@(posedge clock) disable iff (!rstn)
      count_q == (AW+1)'(DEPTH) |-> full_q)
    else $error("full flag missing");
  full_drop_a: assert property (@(posedge clock) disable iff (!rstn)
      (count_q == (AW+1)'(DEPTH) && !pop && !flush) |=> count_q == (AW+1)'(DEPTH))
    else $error("fifo count passed its depth");
  first_push_a: assert property (@(posedge clock) disable iff (!rstn)
      (convDone && count_q == '0 && !flush) |=> count_q == (AW+1)'(1))
    else $error("result not stored in empty fifo");
  pop_step_a: assert property (@(posedge clock) disable iff (!rstn)
      (pop && !flush) |=> rp_q == $past(rp_q) + 1'b1)
    else $error("read pointer did not step");
  data_zero_a: assert property (@(posedge clock) disable iff (!rstn)
      (psel && !penable && !pwrite && hitData && count_q == '0) |=> prdata == 32'h00000000)
    else $error("empty data read not zero");

endmodule : acq_control
`default_nettype wire

// File: conv_model.sv
`default_nettype none
// ****
// converter stand-in
// ****
module conv_model (
  // clock
  input wire logic clock,
  // converter side
  input wire logic convStart,
  input wire logic [3:0] muxSelect,
  output logic [11:0] convData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] seq_q = 8'h00;
  // result carries a running count and the channel, so order and scan show
  always @(posedge clock) begin
    if (convStart) begin
      convData <= {seq_q, muxSelect};
      seq_q <= seq_q + 8'h01;
    end
  end
endmodule : conv_model
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb import acq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, extTrigger, convStart, err;
  logic [7:0] paddr, seq;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] convData, outputCode;
  logic [3:0] muxSelect;
  logic [2:0] gainSetting;
  int num_errors, compares;
  // ****
  // design and converter
  // ****
  acq_control #(.DEPTH(16), .AW(4)) acq_control_inst (.clock(clock), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .extTrigger(extTrigger),
    .convData(convData), .outputCode(outputCode), .muxSelect(muxSelect),
    .gainSetting(gainSetting), .convStart(convStart));
  conv_model conv_model_inst (.clock(clock), .convStart(convStart),
    .muxSelect(muxSelect), .convData(convData));
  // clock source
  always #20 clock = ~clock;
  // ****
  // shared tasks
  // ****
  task automatic stop_test;
    $display("num_errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      stop_test();
    end
  endtask : apb
  // software trigger, then poll busy until the result is stored
  task automatic conv1;
    int n;
    apb(1'b1, OFF_SWTRIG, 32'h0);
    seq = seq + 8'h01;
    repeat (2) @(posedge clock);
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[ST_BUSY], 1'b1);
    n = 0;
    while (rd[ST_BUSY] !== 1'b0 && n < 40) begin
      apb(1'b0, OFF_GAIN, 32'h0);
      n++;
    end
    if (n >= 40) begin
      num_errors++;
      stop_test();
    end
  endtask : conv1
  // ****
  // scenarios
  // ****
  task automatic t_basic;
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd, 32'h10);
    chk({29'h0, gainSetting}, {29'h0, GAIN_X1});
    apb(1'b1, OFF_OUTCODE, 32'hFFF);
    repeat (2) @(posedge clock);
    chk({20'h0, outputCode}, 32'hFFF);
    for (int g = 0; g < 6; g++) begin
      apb(1'b1, OFF_GAIN, g);
      apb(1'b0, OFF_GAIN, 32'h0);
      chk(rd[2:0], (g > 4) ? GAIN_MAX : g[2:0]);
      chk({29'h0, gainSetting}, {29'h0, (g > 4) ? GAIN_MAX : g[2:0]});
    end
    apb(1'b1, OFF_MODE, 32'hA);
    apb(1'b0, OFF_MODE, 32'h0);
    chk(rd[3:0], 4'hA);
    apb(1'b1, OFF_MODE, 32'h5);
    apb(1'b0, OFF_MODE, 32'h0);
    chk(rd[3:0], 4'h5);
    repeat (30) @(posedge clock);
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[ST_EMPTY], 1'b1);
    apb(1'b1, OFF_MODE, 32'h0);
  endtask : t_basic
  task automatic t_single;
    apb(1'b1, OFF_CHSEL, 32'h25);
    conv1();
    apb(1'b0, OFF_CHSEL, 32'h0);
    chk(rd, 32'h05);
    chk({28'h0, muxSelect}, 32'h5);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(rd, {20'h0, seq - 8'h01, 4'h5});
    apb(1'b0, OFF_DATA, 32'h0);
    chk(rd, 32'h0);
  endtask : t_single
  // scan ends at channel 2: expect 0,1,2,0 and the live channel in bits 7:4
  task automatic t_scan;
    logic [7:0] b;
    apb(1'b1, OFF_MODE, 32'h8);
    apb(1'b1, OFF_CHSEL, 32'h2);
    b = seq;
    for (int i = 0; i < 4; i++) begin
      conv1();
      apb(1'b0, OFF_CHSEL, 32'h0);
      chk(rd, {24'h0, 4'((i + 1) % 3), 4'h2});
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, OFF_DATA, 32'h0);
      chk(rd, {20'h0, b + 8'(i), 4'(i % 3)});
    end
    apb(1'b1, OFF_MODE, 32'h0);
  endtask : t_scan
  task automatic t_fill;
    logic [7:0] b;
    apb(1'b1, OFF_FIFORST, 32'h0);
    b = seq;
    for (int i = 0; i < 17; i++) conv1();
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[6:4], 3'b110);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, OFF_DATA, 32'h0);
      chk(rd, {20'h0, b + 8'(i), 4'h2});
    end
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[6:4], 3'b001);
    conv1();
    apb(1'b1, OFF_FIFORST, 32'h0);
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[ST_EMPTY], 1'b1);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_fill
  // pacer every 2*4 cycles stores results in the fifo; a zero divider then stops it
  task automatic t_pacer;
    apb(1'b1, OFF_PACER1, 32'h2);
    apb(1'b1, OFF_PACER2, 32'h4);
    apb(1'b1, OFF_MODE, 32'h4);
    repeat (40) @(posedge clock);
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[ST_EMPTY], 1'b0);
    apb(1'b1, OFF_PACER2, 32'h0);
    repeat (20) @(posedge clock);
    apb(1'b1, OFF_FIFORST, 32'h0);
    repeat (40) @(posedge clock);
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[ST_EMPTY], 1'b1);
    apb(1'b1, OFF_MODE, 32'h0);
  endtask : t_pacer
  // external source: soft writes are ignored, one pin edge gives one result
  task automatic t_ext;
    apb(1'b1, OFF_CHSEL, 32'h7);
    apb(1'b1, OFF_MODE, 32'h2);
    apb(1'b1, OFF_SWTRIG, 32'h0);
    repeat (10) @(posedge clock);
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[ST_EMPTY], 1'b1);
    extTrigger <= 1'b1;
    repeat (4) @(posedge clock);
    extTrigger <= 1'b0;
    repeat (12) @(posedge clock);
    apb(1'b0, OFF_DATA, 32'h0);
    chk(rd[3:0], 4'h7);
    apb(1'b0, OFF_GAIN, 32'h0);
    chk(rd[ST_EMPTY], 1'b1);
    apb(1'b1, OFF_MODE, 32'h0);
  endtask : t_ext
  // ****
  // main sequence
  // ****
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    extTrigger = 1'b0;
    seq = 8'h00;
    num_errors = 0;
    compares = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_basic();
    t_single();
    t_scan();
    t_fill();
    t_pacer();
    t_ext();
    stop_test();
  end
endmodule : tb
`default_nettype wire
